/* File: chad_pkg.sv */
// Constants, types and bundles for the carrier host address decoder.
// Assumes a single 250 MHz clock; the local bus cadence is derived from it.
// Behaviour
// - Registers are picked by I/O offset from host base; 0x0-0x0C, 0x1C pick nothing.
// - 0x10 serial data, 0x14 control/status, 0x18 interrupt control, 0x24/0x40 16-bit.
// - I/O offsets 0x20 to 0x3F, except 0x24 to 0x27, are the readable, writable port configuration region.
// - I/O offsets 0x80 to 0xAF reach the test bus controller as 16-bit accesses.
// - Memory addresses 0 to 0x000F_FFFF reach the 1 MB shared SRAM.
// - Memory 0x0020_0090 behaves exactly like the I/O serial data location.
// - Memory 0x0020_0094 behaves exactly like the I/O control/status location.
// - Memory 0x0020_0098 behaves exactly like the I/O interrupt control location.
// - Memory 0x0020_0240 to 0x0020_025F reach the 16-bit parallel bus data register.
// - Memory 0x0020_0260 to 0x0020_027F reach the parallel bus control/status register.
// - One owner of the local bus at a time: module or bridge.
// - Transfers paced at 31.25 MHz (8 clocks), under 33 MHz; bridge bursts hold 256 words of 32 bits.
// - All offsets and ranges are byte addresses.
package chad_pkg;

    // Local bus pacing: least period, so the divide rounds up.
    localparam int CLK_FREQ_MHZ = 250;
    localparam int LB_FREQ_MHZ  = 33;
    localparam int LB_DIV       = (CLK_FREQ_MHZ + LB_FREQ_MHZ - 1) / LB_FREQ_MHZ;
    localparam int LB_CNT_W     = 4;
    localparam logic [LB_CNT_W-1:0] LB_LAST = LB_CNT_W'(LB_DIV - 1);

    // Bridge burst depth in words per direction.
    localparam int BRIDGE_BURST_WORDS = 256;
    localparam int BURST_CNT_W        = 8;

    // I/O space offsets from the host-assigned base.
    localparam logic [7:0] IO_SERIAL_DATA = 8'h10;
    localparam logic [7:0] IO_CTRL_STAT   = 8'h14;
    localparam logic [7:0] IO_INT_CTRL    = 8'h18;
    localparam logic [7:0] IO_CFG_LO      = 8'h20;
    localparam logic [7:0] IO_CFG_HI      = 8'h3F;
    localparam logic [7:0] IO_PORT_SWITCH = 8'h24;
    localparam logic [7:0] IO_INT_REG     = 8'h40;
    localparam logic [7:0] IO_TEST_LO     = 8'h80;
    localparam logic [7:0] IO_TEST_HI     = 8'hAF;

    // Memory space addresses.
    localparam logic [31:0] MEM_SRAM_HI     = 32'h000F_FFFF;
    localparam logic [31:0] MEM_GLOBAL_LO   = 32'h0020_0000;
    localparam logic [31:0] MEM_GLOBAL_HI   = 32'h0020_007F;
    localparam logic [31:0] MEM_SERIAL_DATA = 32'h0020_0090;
    localparam logic [31:0] MEM_CTRL_STAT   = 32'h0020_0094;
    localparam logic [31:0] MEM_INT_CTRL    = 32'h0020_0098;
    localparam logic [31:0] MEM_PDB_DATA_LO = 32'h0020_0240;
    localparam logic [31:0] MEM_PDB_DATA_HI = 32'h0020_025F;
    localparam logic [31:0] MEM_PDB_CTRL_LO = 32'h0020_0260;
    localparam logic [31:0] MEM_PDB_CTRL_HI = 32'h0020_027F;

    // Global address with lines 30 and 19 high, 7 and 5 low.
    localparam logic [31:0] GLOBAL_SEL_ADDR = 32'h4008_0000;
    localparam logic [31:0] HALF_MASK       = 32'h0000_FFFF;

    // Reset values of the two local 16-bit registers.
    localparam logic [15:0] SWITCH_RESET = 16'h0000;
    localparam logic [15:0] INTERRUPT_REGISTER_RESET = 16'h0000;

    typedef enum logic [0:0] {
        SPACE_IO  = 1'b0,
        SPACE_MEM = 1'b1
    } chad_space_t;

    typedef enum logic [3:0] {
        TGT_NONE        = 4'h0,
        TGT_SERIAL_DATA = 4'h1,
        TGT_CTRL_STAT   = 4'h2,
        TGT_INT_CTRL    = 4'h3,
        TGT_PORT_CFG    = 4'h4,
        TGT_PORT_SWITCH = 4'h5,
        TGT_INT_REG     = 4'h6,
        TGT_TEST_BUS    = 4'h7,
        TGT_SRAM        = 4'h8,
        TGT_GLOBAL      = 4'h9,
        TGT_PDB_DATA    = 4'hA,
        TGT_PDB_CTRL    = 4'hB
    } chad_target_t;

    typedef struct packed {
        logic        write;
        chad_space_t space;
        logic [31:0] addr;
        logic [31:0] wdata;
    } chad_req_t;

    typedef struct packed {
        chad_target_t sel;
        logic         write;
        logic [31:0]  addr;
        logic [31:0]  wdata;
    } chad_tgt_t;

endpackage

/* File: chad_arbiter.sv */
// Local bus owner arbiter between the plugged-in module and the bridge.
// Assumes the module request is already synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
module chad_arbiter (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic mod_req,
    input  wire logic brg_req,
    input  wire logic brg_burst_done,
    output var  logic mod_grant,
    output var  logic brg_grant
);
    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_MOD  = 2'b01,
        OWN_BRG  = 2'b10
    } chad_owner_t;

    chad_owner_t owner_reg, owner_next;
    logic        last_brg_reg, last_brg_next;

    // single owner choice
    // A single owner variable makes a double grant impossible by construction.
    always_comb begin
        owner_next    = owner_reg;
        last_brg_next = last_brg_reg;
        unique case (owner_reg)
            OWN_NONE: begin
                if (mod_req && brg_req) begin
                    owner_next = last_brg_reg ? OWN_MOD : OWN_BRG;
                end else if (mod_req) begin
                    owner_next = OWN_MOD;
                end else if (brg_req) begin
                    owner_next = OWN_BRG;
                end
            end
            OWN_MOD: begin
                if (!mod_req) begin
                    owner_next = brg_req ? OWN_BRG : OWN_NONE;
                end
            end
            OWN_BRG: begin
                // A finished burst yields to a waiting module for fairness.
                if (!brg_req || (brg_burst_done && mod_req)) begin
                    owner_next = mod_req ? OWN_MOD : OWN_NONE;
                end
            end
            default: owner_next = OWN_NONE;
        endcase
        if (owner_next == OWN_BRG) begin
            last_brg_next = 1'b1;
        end else if (owner_next == OWN_MOD) begin
            last_brg_next = 1'b0;
        end
    end

    // Owner and grants register together so grants come from flip-flops.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            owner_reg    <= OWN_NONE;
            last_brg_reg <= 1'b0;
            mod_grant    <= 1'b0;
            brg_grant    <= 1'b0;
        end else if (ce) begin
            owner_reg    <= owner_next;
            last_brg_reg <= last_brg_next;
            mod_grant    <= (owner_next == OWN_MOD);
            brg_grant    <= (owner_next == OWN_BRG);
        end
    end
endmodule
`default_nettype wire

/* File: chad_ioregs.sv */
// The two 16-bit I/O registers held inside the decoder: port switch and interrupt.
// Assumes one strobe per access; read data appear the cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module chad_ioregs (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        stb,
    input  wire logic        write,
    input  wire logic        sel_switch,
    input  wire logic        sel_interrupt_register,
    input  wire logic [15:0] wdata,
    output var  logic [15:0] rdata,
    output var  logic [15:0] port_route_switch,
    output var  logic [15:0] interrupt_register
);
    import chad_pkg::*;

    logic [15:0] switch_next;
    logic [15:0] interrupt_register_next;
    logic [15:0] rdata_next;

    always_comb begin
        switch_next = port_route_switch;
        interrupt_register_next = interrupt_register;
        rdata_next  = rdata;
        if (stb && write && sel_switch) begin
            switch_next = wdata;
        end
        if (stb && write && sel_interrupt_register) begin
            interrupt_register_next = wdata;
        end
        if (stb && !write) begin
            rdata_next = sel_switch ? port_route_switch :
                         sel_interrupt_register ? interrupt_register : 16'h0000;
        end
    end

    // Storage and registered read data.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_route_switch  <= SWITCH_RESET;
            interrupt_register <= INTERRUPT_REGISTER_RESET;
            rdata              <= 16'h0000;
        end else if (ce) begin
            port_route_switch  <= switch_next;
            interrupt_register <= interrupt_register_next;
            rdata              <= rdata_next;
        end
    end
endmodule
`default_nettype wire

/* File: chad_decoder.sv */
// Top of the carrier host address decoder: takes host accesses from the bridge
// side of the local bus, steers them to one target and arbitrates bus ownership.
// Assumes the bridge request bundle is on clk; the module bus request is a pin.
`timescale 1ns/1ns
`default_nettype none
module chad_decoder #(
    parameter int BURST_WORDS = chad_pkg::BRIDGE_BURST_WORDS
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic [31:0]       io_base,
    input  wire logic              req_valid,
    input  wire chad_pkg::chad_req_t req,
    output var  logic              resp_valid,
    output var  logic [31:0]       resp_rdata,
    output var  chad_pkg::chad_tgt_t tgt,
    output var  logic              tgt_stb,
    input  wire logic [31:0]       tgt_rdata,
    input  wire logic              mod_bus_req,
    output var  logic              mod_bus_grant,
    input  wire logic              brg_bus_req,
    output var  logic              brg_bus_grant,
    output var  logic [15:0]       port_route_switch,
    output var  logic [15:0]       interrupt_register
);
    import chad_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_STROBE  = 2'b01,
        ST_SAMPLE  = 2'b10,
        ST_RESPOND = 2'b11
    } chad_state_t;

    localparam logic [BURST_CNT_W-1:0] BURST_LAST = BURST_CNT_W'(BURST_WORDS - 1);

    // byte address compares
    // Single registers are matched on the word, so any byte lane of them hits.
    function automatic chad_target_t decode_target(input chad_space_t space,
                                                   input logic        write,
                                                   input logic [31:0] off);
        chad_target_t t;
        t = TGT_NONE;
        if (space == SPACE_IO) begin
            if (off[31:8] == 24'h00_0000) begin
                if (off[7:2] == IO_SERIAL_DATA[7:2]) begin
                    t = TGT_SERIAL_DATA;
                end else if (off[7:2] == IO_CTRL_STAT[7:2]) begin
                    t = TGT_CTRL_STAT;
                end else if (off[7:2] == IO_INT_CTRL[7:2]) begin
                    // Interrupt control has no read side.
                    t = write ? TGT_INT_CTRL : TGT_NONE;
                end else if (off[7:2] == IO_PORT_SWITCH[7:2]) begin
                    t = TGT_PORT_SWITCH;
                end else if (off[7:2] == IO_INT_REG[7:2]) begin
                    t = TGT_INT_REG;
                end else if (off[7:0] >= IO_CFG_LO && off[7:0] <= IO_CFG_HI) begin
                    t = TGT_PORT_CFG;
                end else if (off[7:0] >= IO_TEST_LO && off[7:0] <= IO_TEST_HI) begin
                    t = TGT_TEST_BUS;
                end
            end
        end else begin
            if (off <= MEM_SRAM_HI) begin
                t = TGT_SRAM;
            end else if (off[31:2] == MEM_SERIAL_DATA[31:2]) begin
                t = TGT_SERIAL_DATA;
            end else if (off[31:2] == MEM_CTRL_STAT[31:2]) begin
                t = TGT_CTRL_STAT;
            end else if (off[31:2] == MEM_INT_CTRL[31:2]) begin
                t = write ? TGT_INT_CTRL : TGT_NONE;
            end else if (off >= MEM_GLOBAL_LO && off <= MEM_GLOBAL_HI) begin
                t = TGT_GLOBAL;
            end else if (off >= MEM_PDB_DATA_LO && off <= MEM_PDB_DATA_HI) begin
                t = TGT_PDB_DATA;
            end else if (off >= MEM_PDB_CTRL_LO && off <= MEM_PDB_CTRL_HI) begin
                t = TGT_PDB_CTRL;
            end
        end
        return t;
    endfunction

    // Targets that carry only the low half-word.
    function automatic logic is_half(input chad_target_t t);
        return (t == TGT_TEST_BUS) || (t == TGT_PORT_SWITCH) ||
               (t == TGT_INT_REG)  || (t == TGT_PDB_DATA);
    endfunction

    // global select lines
    // The module answers only with lines 30 and 19 high and 7 and 5 low, so the
    // window offset bits 6:5 move up to 9:8 and bits 7:5 are kept low.
    function automatic logic [31:0] global_addr(input logic [31:0] off);
        return GLOBAL_SEL_ADDR | {22'h00_0000, off[6:5], 3'b000, off[4:0]};
    endfunction

    // Synchroniser for the module bus request pin; only stage two is read.
    logic mod_req_meta_reg;
    logic mod_req_sync_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mod_req_meta_reg <= 1'b0;
            mod_req_sync_reg <= 1'b0;
        end else if (ce) begin
            mod_req_meta_reg <= mod_bus_req;
            mod_req_sync_reg <= mod_req_meta_reg;
        end
    end

    // local bus cadence
    // A request is only taken on a tick, so accesses never outrun 33 MHz.
    logic [LB_CNT_W-1:0] lb_cnt_reg, lb_cnt_next;
    logic                lb_tick_reg, lb_tick_next;

    always_comb begin
        lb_cnt_next  = (lb_cnt_reg == LB_LAST) ? '0 : lb_cnt_reg + 1'b1;
        lb_tick_next = (lb_cnt_reg == LB_LAST);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lb_cnt_reg  <= '0;
            lb_tick_reg <= 1'b0;
        end else if (ce) begin
            lb_cnt_reg  <= lb_cnt_next;
            lb_tick_reg <= lb_tick_next;
        end
    end

    // Access sequencer state.
    chad_state_t         state_reg, state_next;
    chad_tgt_t           tgt_next;
    logic                tgt_stb_next;
    logic                resp_valid_next;
    logic [31:0]         resp_rdata_next;
    logic [BURST_CNT_W-1:0] burst_cnt_reg, burst_cnt_next;
    logic                burst_done;
    logic                take;
    logic [31:0]         off;
    chad_target_t        sel;
    logic [15:0]         local_rdata;
    logic                local_sel;

    assign take = (state_reg == ST_IDLE) && lb_tick_reg && req_valid && brg_bus_grant;
    assign off = (req.space == SPACE_IO) ? (req.addr - io_base) : req.addr;
    assign sel = decode_target(req.space, req.write, off);
    assign local_sel = (tgt.sel == TGT_PORT_SWITCH) || (tgt.sel == TGT_INT_REG);
    assign burst_done = (state_reg == ST_RESPOND) && (burst_cnt_reg == BURST_LAST);

    // Next state, target bundle, response and burst count.
    always_comb begin
        state_next      = state_reg;
        tgt_next        = tgt;
        tgt_stb_next    = 1'b0;
        resp_valid_next = 1'b0;
        resp_rdata_next = resp_rdata;
        burst_cnt_next  = brg_bus_grant ? burst_cnt_reg : '0;
        unique case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next     = ST_STROBE;
                    tgt_next.sel   = sel;
                    tgt_next.write = req.write;
                    tgt_next.addr  = (sel == TGT_GLOBAL) ? global_addr(off) : off;
                    tgt_next.wdata = is_half(sel) ? (req.wdata & HALF_MASK) : req.wdata;
                    tgt_stb_next   = (sel != TGT_NONE);
                end
            end
            ST_STROBE: begin
                state_next = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                state_next      = ST_RESPOND;
                resp_valid_next = 1'b1;
                if (tgt.write || tgt.sel == TGT_NONE) begin
                    resp_rdata_next = 32'h0000_0000;
                end else if (local_sel) begin
                    resp_rdata_next = {16'h0000, local_rdata};
                end else if (is_half(tgt.sel)) begin
                    resp_rdata_next = tgt_rdata & HALF_MASK;
                end else begin
                    resp_rdata_next = tgt_rdata;
                end
            end
            ST_RESPOND: begin
                state_next     = ST_IDLE;
                burst_cnt_next = burst_done ? '0 : burst_cnt_reg + 1'b1;
            end
        endcase
    end

    // Registers of the access sequencer; every top output here is a flip-flop.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= ST_IDLE;
            tgt           <= '0;
            tgt_stb       <= 1'b0;
            resp_valid    <= 1'b0;
            resp_rdata    <= 32'h0000_0000;
            burst_cnt_reg <= '0;
        end else if (ce) begin
            state_reg     <= state_next;
            tgt           <= tgt_next;
            tgt_stb       <= tgt_stb_next;
            resp_valid    <= resp_valid_next;
            resp_rdata    <= resp_rdata_next;
            burst_cnt_reg <= burst_cnt_next;
        end
    end

    // Local half-word registers, strobed in the same cycle as external targets.
    chad_ioregs u_ioregs (
        .clk                (clk),
        .reset_n            (reset_n),
        .ce                 (ce),
        .stb                (tgt_stb),
        .write              (tgt.write),
        .sel_switch         (tgt.sel == TGT_PORT_SWITCH),
        .sel_interrupt_register         (tgt.sel == TGT_INT_REG),
        .wdata              (tgt.wdata[15:0]),
        .rdata              (local_rdata),
        .port_route_switch  (port_route_switch),
        .interrupt_register (interrupt_register)
    );

    chad_arbiter u_arbiter (
        .clk            (clk),
        .reset_n        (reset_n),
        .ce             (ce),
        .mod_req        (mod_req_sync_reg),
        .brg_req        (brg_bus_req),
        .brg_burst_done (burst_done),
        .mod_grant      (mod_bus_grant),
        .brg_grant      (brg_bus_grant)
    );
endmodule
`default_nettype wire

/* File: chad_decoder_assertions.sv */
// Port checker for the host address decoder top.
// Assumes it is bound to chad_decoder and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module chad_decoder_assertions (
    input wire logic                clk,
    input wire logic                reset_n,
    input wire logic                ce,
    input wire logic                tgt_stb,
    input wire chad_pkg::chad_tgt_t tgt,
    input wire logic [31:0]         tgt_rdata,
    input wire logic                resp_valid,
    input wire logic [31:0]         resp_rdata,
    input wire logic                mod_bus_grant,
    input wire logic                brg_bus_grant,
    input wire logic                brg_bus_req
);
    import chad_pkg::*;
    // All checks share the one clock, so reset and a frozen enable disable them in one place.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || !ce);
    grant_exclusive_a: assert property (!(mod_bus_grant && brg_bus_grant))
        else $error("both bus grants high");
    grant_release_a: assert property (!brg_bus_req |=> !brg_bus_grant)
        else $error("bridge grant kept after request dropped");
    stb_owner_a: assert property (tgt_stb |-> $past(brg_bus_grant))
        else $error("strobe without bridge ownership");
    stb_resp_a: assert property (tgt_stb |=> !resp_valid ##1 resp_valid)
        else $error("response not two cycles after strobe");
    stb_spacing_a: assert property (tgt_stb |=> !tgt_stb [*7])
        else $error("strobes closer than the local bus tick");
    stb_mapped_a: assert property (tgt_stb |-> tgt.sel != TGT_NONE)
        else $error("strobe on unmapped target");
    write_zero_a: assert property (tgt_stb && tgt.write |-> ##2 resp_rdata == 32'h0)
        else $error("write response data not zero");
    serial_read_a: assert property (tgt_stb && !tgt.write && tgt.sel == TGT_SERIAL_DATA
        |=> ##1 resp_rdata == $past(tgt_rdata)) else $error("serial read data lost");
    sram_range_a: assert property (tgt_stb && tgt.sel == TGT_SRAM
        |-> tgt.addr <= 32'h000F_FFFF) else $error("SRAM select out of range");
    test_half_a: assert property (tgt_stb && tgt.sel == TGT_TEST_BUS
        |-> tgt.addr inside {[32'h80:32'hAF]} && tgt.wdata[31:16] == 16'h0)
        else $error("test bus access malformed");
    global_lines_a: assert property (tgt_stb && tgt.sel == TGT_GLOBAL
        |-> tgt.addr[30] && tgt.addr[19] && !tgt.addr[7] && !tgt.addr[5])
        else $error("global address lines wrong");
    pdb_half_a: assert property (tgt_stb && tgt.sel == TGT_PDB_DATA
        |-> tgt.wdata[31:16] == 16'h0) else $error("parallel data not 16 bit");
endmodule
bind chad_decoder chad_decoder_assertions u_chk (.clk, .reset_n, .ce, .tgt_stb, .tgt,
    .tgt_rdata, .resp_valid, .resp_rdata, .mod_bus_grant, .brg_bus_grant, .brg_bus_req);
`default_nettype wire

/* File: chad_tgt_model.sv */
// Far-side target model: answers each decoder strobe with a read word.
// Assumes tgt_rdata is sampled in the cycle after tgt_stb.
`timescale 1ns/1ns
`default_nettype none
module chad_tgt_model (
    input  wire logic                clk,
    input  wire chad_pkg::chad_tgt_t tgt,
    input  wire logic                tgt_stb,
    output var  logic [31:0]         tgt_rdata
);
    import chad_pkg::*;
    // module line decode
    // Off the answer cycle the bus toggles, so stale data can never pass.
    always_ff @(posedge clk) begin
        if (tgt_stb && (tgt.sel != TGT_GLOBAL || (tgt.addr[30] && tgt.addr[19]
                && !tgt.addr[7] && !tgt.addr[5]))) begin
            tgt_rdata <= tgt.addr ^ 32'hA5C3_0000 ^ {28'h0, tgt.sel};
        end else begin
            tgt_rdata <= ~tgt_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// Bench for the host address decoder: bridge tasks, target model, map checks.
// Assumes chad_pkg and a short forced burst of 4 words.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import chad_pkg::*;
    logic        clk, reset_n, ce, req_valid, tgt_stb, resp_valid;
    logic        mod_bus_req, mod_bus_grant, brg_bus_req, brg_bus_grant;
    logic [31:0] io_base, resp_rdata, tgt_rdata, r;
    logic [15:0] port_route_switch, interrupt_register, sw_m, ir_m;
    chad_req_t   req;
    chad_tgt_t   tgt;
    int          n_errors, n_compared, seed, i, k;
    logic [31:0] io_c [14] = '{32'h0, 32'hC, 32'h10, 32'h14, 32'h18, 32'h1C, 32'h20,
        32'h24, 32'h3C, 32'h40, 32'h80, 32'hAC, 32'hB0, 32'h100};
    logic [31:0] mem_c [13] = '{32'h0, 32'hF_FFFC, 32'h10_0000, 32'h20_0000, 32'h20_007C,
        32'h20_0090, 32'h20_0094, 32'h20_0098, 32'h20_0240, 32'h20_025C, 32'h20_0260,
        32'h20_027C, 32'h20_0280};
    chad_decoder #(.BURST_WORDS(4)) DUT (.clk, .reset_n, .ce, .io_base, .req_valid, .req,
        .resp_valid, .resp_rdata, .tgt, .tgt_stb, .tgt_rdata, .mod_bus_req, .mod_bus_grant,
        .brg_bus_req, .brg_bus_grant, .port_route_switch, .interrupt_register);
    chad_tgt_model PM (.clk(clk), .tgt(tgt), .tgt_stb(tgt_stb), .tgt_rdata(tgt_rdata));
    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic hung();
        n_errors++;
        print_verdict();
    endtask
    // Target the map should pick; a read of the write-only slot picks nothing.
    function automatic chad_target_t exp_sel(logic mem, logic wr, logic [31:0] a);
        if (mem) begin
            if (a <= 32'h000F_FFFF) return TGT_SRAM;
            if (a == 32'h0020_0090) return TGT_SERIAL_DATA;
            if (a == 32'h0020_0094) return TGT_CTRL_STAT;
            if (a == 32'h0020_0098) return wr ? TGT_INT_CTRL : TGT_NONE;
            if (a inside {[32'h0020_0000:32'h0020_007F]}) return TGT_GLOBAL;
            if (a inside {[32'h0020_0240:32'h0020_025F]}) return TGT_PDB_DATA;
            if (a inside {[32'h0020_0260:32'h0020_027F]}) return TGT_PDB_CTRL;
            return TGT_NONE;
        end
        if (a == 32'h10) return TGT_SERIAL_DATA;
        if (a == 32'h14) return TGT_CTRL_STAT;
        if (a == 32'h18) return wr ? TGT_INT_CTRL : TGT_NONE;
        if (a == 32'h24) return TGT_PORT_SWITCH;
        if (a inside {[32'h20:32'h3F]}) return TGT_PORT_CFG;
        if (a == 32'h40) return TGT_INT_REG;
        if (a inside {[32'h80:32'hAF]}) return TGT_TEST_BUS;
        return TGT_NONE;
    endfunction
    // One bridge access, held until the response pulse, then checked in full except strobe presence for the port switch and interrupt register.
    task automatic access(input logic wr, input logic mem, input logic [31:0] a);
        chad_target_t s;
        logic [31:0]  ea, wd, er;
        logic         seen, h;
        wd = $random(seed);
        s = exp_sel(mem, wr, a);
        h = s inside {TGT_TEST_BUS, TGT_PORT_SWITCH, TGT_INT_REG, TGT_PDB_DATA};
        ea = (s == TGT_GLOBAL) ? 32'h4008_0000 | {22'h0, a[6:5], 3'h0, a[4:0]} : a;
        seen = 1'b0;
        req = '{wr, chad_space_t'(mem), mem ? a : io_base + a, wd};
        req_valid = 1'b1;
        for (k = 0; k < 100 && resp_valid !== 1'b1; k++) begin
            @(negedge clk);
            if (tgt_stb === 1'b1) begin
                seen = 1'b1;
                check({28'h0, tgt.sel}, {28'h0, s});
                check(tgt.addr, ea);
                check(tgt.wdata, h ? wd & 32'h0000_FFFF : wd);
            end
        end
        if (k == 100) hung();
        er = ea ^ 32'hA5C3_0000 ^ {28'h0, s};
        if (h) er = er & 32'h0000_FFFF;
        if (s == TGT_PORT_SWITCH) er = {16'h0, sw_m};
        if (s == TGT_INT_REG) er = {16'h0, ir_m};
        if (wr || s == TGT_NONE) er = 32'h0;
        check(resp_rdata, er);
        if (s != TGT_PORT_SWITCH && s != TGT_INT_REG) check(seen, s != TGT_NONE);
        req_valid = 1'b0;
        if (wr && s == TGT_PORT_SWITCH) sw_m = wd[15:0];
        if (wr && s == TGT_INT_REG) ir_m = wd[15:0];
        @(negedge clk);
        check(port_route_switch, sw_m);
        check(interrupt_register, ir_m);
    endtask
    task automatic wait_grant(input logic m);
        for (k = 0; k < 40 && (m ? mod_bus_grant : brg_bus_grant) !== 1'b1; k++) begin
            @(negedge clk);
        end
        if (k == 40) hung();
    endtask
    // Reset, fixed map corners, random traffic, then ownership hand-overs.
    initial begin
        seed = 87;
        reset_n = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        mod_bus_req = 1'b0;
        brg_bus_req = 1'b0;
        io_base = {$random(seed)} & 32'hFFFF_FF00;
        sw_m = 16'h0000;
        ir_m = 16'h0000;
        repeat (4) @(negedge clk);
        check(brg_bus_grant, 1'b0);
        check(port_route_switch, 16'h0000);
        reset_n = 1'b1;
        brg_bus_req = 1'b1;
        foreach (io_c[j]) begin
            access(1'b1, 1'b0, io_c[j]);
            access(1'b0, 1'b0, io_c[j]);
        end
        foreach (mem_c[j]) begin
            access(1'b1, 1'b1, mem_c[j]);
            access(1'b0, 1'b1, mem_c[j]);
        end
        $display("map corners done");
        for (i = 0; i < 150; i++) begin
            r = $random(seed);
            if (r[0]) access(r[1], 1'b1, r[2] ? r & 32'h000F_FFFC : 32'h0020_0000 | (r & 32'h3FC));
            else access(r[1], 1'b0, r & 32'h1FC);
        end
        $display("random traffic done");
        brg_bus_req = 1'b0;
        @(negedge clk);
        check(brg_bus_grant, 1'b0);
        // The module request needs two edges through the synchroniser to meet the bridge's.
        mod_bus_req = 1'b1;
        repeat (2) @(negedge clk);
        brg_bus_req = 1'b1;
        wait_grant(1'b1);
        repeat (8) @(negedge clk);
        check(brg_bus_grant, 1'b0);
        // Clock enable low must freeze the grant.
        ce = 1'b0;
        mod_bus_req = 1'b0;
        repeat (6) @(negedge clk);
        check(mod_bus_grant, 1'b1);
        ce = 1'b1;
        wait_grant(1'b0);
        mod_bus_req = 1'b1;
        repeat (3) access(1'b0, 1'b1, 32'h0000_0100);
        check(brg_bus_grant, 1'b1);
        access(1'b0, 1'b1, 32'h0000_0104);
        wait_grant(1'b1);
        check(brg_bus_grant, 1'b0);
        mod_bus_req = 1'b0;
        wait_grant(1'b0);
        $display("arbitration done");
        print_verdict();
    end
endmodule
`default_nettype wire
